// >>> rtl/efa_params.svh
// Constants for the embedded flash array access block
`ifndef EFA_PARAMS_SVH
`define EFA_PARAMS_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define EFA_SECTORS          64
`define EFA_PAGES_PER_SECTOR 33
`define EFA_PAGE_BYTES       128
`define EFA_BLKS_PER_PAGE    8
`define EFA_BLK_BITS         128
`define EFA_CHK_BITS         9
`define EFA_CW_BITS          137
`define EFA_NUM_BLKS         16896
`define EFA_BLK_ADDR_W       15
`define EFA_MAX_ARRAYS       4

// ****************************************************************
// User ROM and test port
// ****************************************************************
`define EFA_ROM_PAGES        8
`define EFA_TP_KEY           128'h5a3c_96e1_0f78_d2b4_1e6a_c753_9b08_f4d1

`endif

// >>> rtl/efa_pkg.sv
// Types shared by the embedded flash array access block
package efa_pkg;

  typedef enum logic [1:0] {
    EFA_OP_READ,
    EFA_OP_WRITE,
    EFA_OP_PROGRAM,
    EFA_OP_ERASE
  } efa_op_t;

  typedef enum logic [1:0] {
    EFA_W8,
    EFA_W16,
    EFA_W32
  } efa_width_t;

  typedef enum logic [1:0] {
    EFA_TP_ARRAY,
    EFA_TP_ROM_WR,
    EFA_TP_ROM_ERASE,
    EFA_TP_ROM_RD
  } efa_tp_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_ADDR,
    ST_RD_DATA,
    ST_RA_ADDR,
    ST_RA_DATA,
    ST_LD_ADDR,
    ST_LD_DATA,
    ST_MERGE,
    ST_COMMIT,
    ST_TP_WR
  } efa_state_t;

endpackage : efa_pkg

// >>> rtl/efa_mem.sv
// Block storage of one flash array with registered read data
`timescale 1ns/1ps
`include "efa_params.svh"

module efa_mem #(
  parameter int DEPTH = `EFA_NUM_BLKS,
  parameter int WIDTH = `EFA_CW_BITS,
  parameter int AW    = `EFA_BLK_ADDR_W
) (
  // Clock
  input  wire logic             clk_sys_in,
  // Access
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    addr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end

endmodule : efa_mem

// >>> rtl/efa_ecc.sv
// Block check bit encoder and single-correct double-detect decoder
`timescale 1ns/1ps
`include "efa_params.svh"

module efa_ecc (
  // Encoder
  input  wire logic [`EFA_BLK_BITS-1:0] enc_data_in,
  output logic      [`EFA_CW_BITS-1:0]  enc_word_out,
  // Decoder
  input  wire logic [`EFA_CW_BITS-1:0]  dec_word_in,
  output logic      [`EFA_BLK_BITS-1:0] dec_data_out,
  output logic                          dec_corr_out,
  output logic                          dec_dbl_out
);

  logic [`EFA_CW_BITS-1:0] fixed;
  logic [7:0]              syn;

  function automatic logic [`EFA_CW_BITS-1:0] ecc_encode(
    input logic [`EFA_BLK_BITS-1:0] d);
    logic [`EFA_CW_BITS-1:0] cw;
    int                      j;
    cw = '0;
    j = 0;
    for (int p = 1; p < `EFA_CW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 8; k++) begin
      for (int p = 1; p < `EFA_CW_BITS; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          cw[1 << k] = cw[1 << k] ^ cw[p];
        end
      end
    end
    cw[0] = ^cw[`EFA_CW_BITS-1:1];
    return cw;
  endfunction : ecc_encode

  function automatic logic [`EFA_BLK_BITS-1:0] ecc_extract(
    input logic [`EFA_CW_BITS-1:0] cw);
    logic [`EFA_BLK_BITS-1:0] d;
    int                       j;
    d = '0;
    j = 0;
    for (int p = 1; p < `EFA_CW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = cw[p];
        j++;
      end
    end
    return d;
  endfunction : ecc_extract

  // ****************************************************************
  // Encode and decode
  // ****************************************************************
  assign enc_word_out = ecc_encode(enc_data_in);

  always_comb begin
    syn = 8'h00;
    for (int p = 1; p < `EFA_CW_BITS; p++) begin
      if (dec_word_in[p]) begin
        syn = syn ^ 8'(p);
      end
    end
    fixed = dec_word_in;
    dec_corr_out = 1'b0;
    dec_dbl_out = 1'b0;
    if (^dec_word_in) begin
      if (syn < 8'(`EFA_CW_BITS)) begin
        dec_corr_out = 1'b1;
        fixed[syn] = ~fixed[syn];
      end else begin
        dec_dbl_out = 1'b1;
      end
    end else if (syn != 8'h00) begin
      dec_dbl_out = 1'b1;
    end
    dec_data_out = ecc_extract(fixed);
  end

endmodule : efa_ecc

// >>> rtl/efa_ctrl.sv
// Controller of one embedded flash array with user ROM and test port
`timescale 1ns/1ps
`include "efa_params.svh"

// Overview of operation
// R1 - 64 sectors, 33 pages, 128-byte pages
// R2 - Port width selectable: 8, 16 or 32
// R3 - Buffer hits answer without wait; read-ahead
// R4 - Partitions must fall on page boundaries
// R5 - Each array its own independent controller
// R6 - Page buffer holds modified page, 8 blocks
// R7 - Block buffer keeps last 128-bit block
// R8 - Check bits: correct single, detect double
// R9 - Protected array or sectors refuse changes
// R10 - Test port decrypts stream, then programs
// R11 - User ROM is eight 128-bit pages
// R12 - ROM pages erased and written individually
// R13 - ROM read by test port and fabric
// R14 - Corrected and uncorrectable errors reported; buffer hits answer with both flags low
// R15 - Request/acknowledge handshake with busy flag
module efa_ctrl #(
  parameter logic [1:0]   ARRAY_ID = 2'h0,
  parameter logic [127:0] TP_KEY   = `EFA_TP_KEY
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  arst_n_in,
  // Parallel request port
  input  wire logic                  req_in,
  input  wire efa_pkg::efa_op_t      op_in,
  input  wire logic [1:0]            array_sel_in,
  input  wire logic [5:0]            sector_in,
  input  wire logic [5:0]            page_in,
  input  wire logic [6:0]            byte_in,
  input  wire efa_pkg::efa_width_t   width_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  read_ahead_in,
  // Parallel answer
  output logic                       ack_out,
  output logic                       err_out,
  output logic                       busy_out,
  output logic [31:0]                rdata_out,
  output logic                       ecc_corr_out,
  output logic                       ecc_dbl_out,
  // Write protection
  input  wire logic                  prot_all_in,
  input  wire logic [`EFA_SECTORS-1:0] prot_sector_in,
  // Serial test port
  input  wire logic                  tp_shift_in,
  input  wire logic                  tp_bit_in,
  input  wire logic                  tp_go_in,
  input  wire efa_pkg::efa_tp_cmd_t  tp_cmd_in,
  input  wire logic                  tp_encrypted_in,
  input  wire logic [`EFA_BLK_ADDR_W-1:0] tp_addr_in,
  output logic                       tp_bit_out,
  output logic                       tp_done_out,
  // User ROM fabric read
  input  wire logic [2:0]            rom_page_in,
  output logic [`EFA_BLK_BITS-1:0]   rom_data_out
);
  import efa_pkg::*;

  localparam int BW = `EFA_BLK_BITS;
  localparam int AW = `EFA_BLK_ADDR_W;

  efa_state_t             state;
  logic [2:0]             cnt;
  efa_op_t                r_op;
  efa_width_t             r_w;
  logic [AW-1:0]          r_blk;
  logic [3:0]             r_off;
  logic [31:0]            r_wdata;
  logic [5:0]             r_sec;
  logic [5:0]             r_pg;
  logic                   r_ra;
  logic [BW-1:0]          blk_buf;
  logic [AW-1:0]          blk_tag;
  logic                   blk_valid;
  logic [BW-1:0]          ra_buf;
  logic [AW-1:0]          ra_tag;
  logic                   ra_valid;
  logic [BW-1:0]          pg_buf [`EFA_BLKS_PER_PAGE];
  logic [5:0]             pg_sec;
  logic [5:0]             pg_pg;
  logic                   pg_valid;
  logic                   pg_dirty;
  logic [BW-1:0]          rom [`EFA_ROM_PAGES];
  logic [BW-1:0]          tp_sr;
  logic [BW-1:0]          tp_data_q;
  logic [AW-1:0]          tp_addr_q;
  efa_tp_cmd_t            tp_cmd_q;
  logic                   tp_pend;
  logic                   tp_serve;
  logic                   tp_prot;
  logic                   tp_clr;
  logic                   req_take;
  logic [AW-1:0]          req_blk;
  logic                   req_page_hit;
  logic                   mem_we;
  logic [AW-1:0]          mem_addr;
  logic [BW-1:0]          enc_in;
  logic [`EFA_CW_BITS-1:0] mem_wdata;
  logic [`EFA_CW_BITS-1:0] mem_rdata;
  logic [BW-1:0]          dec_data;
  logic                   dec_corr;
  logic                   dec_dbl;
  logic [5:0]             cm_sec;
  logic [5:0]             cm_pg;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [AW-1:0] blk_index(input logic [5:0] sec,
    input logic [5:0] pg, input logic [2:0] blk);
    return (AW'(sec) * AW'(`EFA_PAGES_PER_SECTOR) + AW'(pg))
      * AW'(`EFA_BLKS_PER_PAGE) + AW'(blk);
  endfunction : blk_index

  function automatic logic [5:0] sector_of(input logic [AW-1:0] idx);
    return 6'(idx / AW'(`EFA_PAGES_PER_SECTOR * `EFA_BLKS_PER_PAGE));
  endfunction : sector_of

  function automatic logic [3:0] align_off(input logic [3:0] off,
    input efa_width_t w);
    unique case (w)
      EFA_W8:  return off;
      EFA_W16: return {off[3:1], 1'b0};
      EFA_W32: return {off[3:2], 2'b00};
      default: return off;
    endcase
  endfunction : align_off

  function automatic logic [2:0] width_bytes(input efa_width_t w);
    unique case (w)
      EFA_W8:  return 3'h1;
      EFA_W16: return 3'h2;
      EFA_W32: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : width_bytes

  function automatic logic [31:0] lane(input logic [BW-1:0] b,
    input logic [3:0] off, input efa_width_t w);
    logic [BW-1:0] sh;
    sh = b >> {align_off(off, w), 3'h0};
    unique case (w)
      EFA_W16: return sh[31:0] & 32'h0000_ffff;
      EFA_W32: return sh[31:0];
      default: return sh[31:0] & 32'h0000_00ff;
    endcase
  endfunction : lane

  function automatic logic is_prot(input logic [5:0] sec);
    return prot_all_in || prot_sector_in[sec];
  endfunction : is_prot

  // ****************************************************************
  // Request decode
  // ****************************************************************
  assign req_take = req_in && !ack_out && !tp_pend
    && array_sel_in == ARRAY_ID && state == ST_IDLE;  // [R5] [R15]
  assign req_blk = blk_index(sector_in, page_in, byte_in[6:4]);  // [R1]
  assign req_page_hit = pg_valid && pg_sec == sector_in
    && pg_pg == page_in;  // [R4]
  assign tp_serve = tp_pend && state == ST_IDLE;
  assign tp_prot = is_prot(sector_of(tp_addr_q));  // [R9]
  assign tp_clr = state == ST_TP_WR
    || (tp_serve && (tp_cmd_q != EFA_TP_ARRAY || tp_prot));
  assign cm_sec = r_op == EFA_OP_ERASE ? r_sec : pg_sec;
  assign cm_pg = r_op == EFA_OP_ERASE ? r_pg : pg_pg;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r_op <= EFA_OP_READ;
      r_w <= EFA_W8;
      r_blk <= '0;
      r_off <= 4'h0;
      r_wdata <= 32'h0000_0000;
      r_sec <= 6'h00;
      r_pg <= 6'h00;
      r_ra <= 1'b0;
    end else if (req_take) begin
      r_op <= op_in;
      r_w <= width_in;  // [R2]
      r_blk <= req_blk;
      r_off <= byte_in[3:0];
      r_wdata <= wdata_in;
      r_sec <= sector_in;
      r_pg <= page_in;
      r_ra <= read_ahead_in;
    end
  end

  // ****************************************************************
  // Storage and check bits
  // ****************************************************************
  always_comb begin
    mem_we = 1'b0;
    mem_addr = r_blk;
    enc_in = tp_data_q;
    unique case (state)
      ST_RA_ADDR: mem_addr = AW'(blk_tag + 1'b1);  // [R3]
      ST_LD_ADDR: mem_addr = blk_index(r_sec, r_pg, cnt);
      ST_COMMIT: begin
        mem_we = 1'b1;
        mem_addr = blk_index(cm_sec, cm_pg, cnt);
        enc_in = r_op == EFA_OP_ERASE ? '1 : pg_buf[cnt];
      end
      ST_TP_WR: begin
        mem_we = 1'b1;
        mem_addr = tp_addr_q;  // [R10]
      end
      ST_IDLE, ST_RD_ADDR, ST_RD_DATA, ST_RA_DATA, ST_LD_DATA,
      ST_MERGE: ;
    endcase
  end

  efa_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .we_in      (mem_we),
    .addr_in    (mem_addr),
    .wdata_in   (mem_wdata),
    .rdata_out  (mem_rdata)
  );

  efa_ecc u_ecc (
    .enc_data_in  (enc_in),
    .enc_word_out (mem_wdata),
    .dec_word_in  (mem_rdata),
    .dec_data_out (dec_data),
    .dec_corr_out (dec_corr),
    .dec_dbl_out  (dec_dbl)
  );  // [R8]

  // ****************************************************************
  // Control sequence, buffers and answers
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      ack_out <= 1'b0;
      err_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      ecc_corr_out <= 1'b0;
      ecc_dbl_out <= 1'b0;
      blk_buf <= '0;
      blk_tag <= '0;
      blk_valid <= 1'b0;
      ra_buf <= '0;
      ra_tag <= '0;
      ra_valid <= 1'b0;
      pg_sec <= 6'h00;
      pg_pg <= 6'h00;
      pg_valid <= 1'b0;
      pg_dirty <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          ack_out <= 1'b0;
          err_out <= 1'b0;
          ecc_corr_out <= 1'b0;
          ecc_dbl_out <= 1'b0;
          if (tp_serve && tp_cmd_q == EFA_TP_ARRAY && !tp_prot) begin
            state <= ST_TP_WR;
          end else if (req_take) begin
            cnt <= 3'h0;
            unique case (op_in)
              EFA_OP_READ: begin
                if (blk_valid && blk_tag == req_blk) begin
                  ack_out <= 1'b1;  // [R3] [R7]
                  rdata_out <= lane(blk_buf, byte_in[3:0], width_in);
                end else if (ra_valid && ra_tag == req_blk) begin
                  ack_out <= 1'b1;  // [R3]
                  rdata_out <= lane(ra_buf, byte_in[3:0], width_in);
                  blk_buf <= ra_buf;
                  blk_tag <= ra_tag;
                  ra_valid <= 1'b0;
                  if (read_ahead_in
                      && ra_tag != AW'(`EFA_NUM_BLKS - 1)) begin
                    state <= ST_RA_ADDR;
                  end
                end else begin
                  state <= ST_RD_ADDR;
                end
              end
              EFA_OP_WRITE: begin
                if (is_prot(sector_in)
                    || (pg_dirty && !req_page_hit)) begin
                  ack_out <= 1'b1;  // [R9]
                  err_out <= 1'b1;
                end else if (req_page_hit) begin
                  state <= ST_MERGE;
                end else begin
                  state <= ST_LD_ADDR;  // [R6]
                end
              end
              EFA_OP_PROGRAM: begin
                if (!pg_dirty) begin
                  ack_out <= 1'b1;
                end else if (is_prot(pg_sec)) begin
                  ack_out <= 1'b1;  // [R9]
                  err_out <= 1'b1;
                end else begin
                  state <= ST_COMMIT;
                end
              end
              EFA_OP_ERASE: begin
                if (is_prot(sector_in)) begin
                  ack_out <= 1'b1;  // [R9]
                  err_out <= 1'b1;
                end else begin
                  state <= ST_COMMIT;
                end
              end
            endcase
          end
        end
        ST_RD_ADDR: state <= ST_RD_DATA;
        ST_RD_DATA: begin
          blk_buf <= dec_data;  // [R7]
          blk_tag <= r_blk;
          blk_valid <= 1'b1;
          ack_out <= 1'b1;
          rdata_out <= lane(dec_data, r_off, r_w);  // [R2]
          ecc_corr_out <= dec_corr;  // [R14]
          ecc_dbl_out <= dec_dbl;  // [R14]
          state <= r_ra && r_blk != AW'(`EFA_NUM_BLKS - 1)
            ? ST_RA_ADDR : ST_IDLE;  // [R3]
        end
        ST_RA_ADDR: begin
          ack_out <= 1'b0;
          ecc_corr_out <= 1'b0;
          ecc_dbl_out <= 1'b0;
          state <= ST_RA_DATA;
        end
        ST_RA_DATA: begin
          ra_buf <= dec_data;
          ra_tag <= AW'(blk_tag + 1'b1);
          ra_valid <= !dec_dbl;
          state <= ST_IDLE;
        end
        ST_LD_ADDR: state <= ST_LD_DATA;
        ST_LD_DATA: begin
          ecc_corr_out <= ecc_corr_out | dec_corr;  // [R14]
          ecc_dbl_out <= ecc_dbl_out | dec_dbl;
          cnt <= 3'(cnt + 1'b1);
          if (cnt == 3'(`EFA_BLKS_PER_PAGE - 1)) begin
            pg_valid <= 1'b1;
            pg_sec <= r_sec;
            pg_pg <= r_pg;
            state <= ST_MERGE;
          end else begin
            state <= ST_LD_ADDR;
          end
        end
        ST_MERGE: begin
          pg_dirty <= 1'b1;
          ack_out <= 1'b1;  // [R15]
          state <= ST_IDLE;
        end
        ST_COMMIT: begin
          cnt <= 3'(cnt + 1'b1);
          if (cnt == 3'(`EFA_BLKS_PER_PAGE - 1)) begin
            blk_valid <= 1'b0;
            ra_valid <= 1'b0;
            if (r_op != EFA_OP_ERASE
                || (pg_sec == r_sec && pg_pg == r_pg)) begin
              pg_dirty <= 1'b0;  // [R15]
              pg_valid <= r_op != EFA_OP_ERASE;
            end
            ack_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_TP_WR: begin
          blk_valid <= 1'b0;
          ra_valid <= 1'b0;
          if (!pg_dirty) begin
            pg_valid <= 1'b0;
          end
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= state != ST_IDLE || tp_pend || req_take;  // [R15]
    end
  end

  // ****************************************************************
  // Page buffer
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (state == ST_LD_DATA) begin
      pg_buf[cnt] <= dec_data;  // [R6]
    end else if (state == ST_MERGE) begin
      for (int k = 0; k < 4; k++) begin
        if (k < int'(width_bytes(r_w))) begin
          pg_buf[r_blk[2:0]][{4'(align_off(r_off, r_w) + 4'(k)), 3'h0}
            +: 8] <= r_wdata[k*8 +: 8];  // [R2] [R6]
        end
      end
    end
  end

  // ****************************************************************
  // Serial test port
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tp_sr <= '0;
      tp_data_q <= '0;
      tp_addr_q <= '0;
      tp_cmd_q <= EFA_TP_ARRAY;
      tp_pend <= 1'b0;
      tp_done_out <= 1'b0;
    end else begin
      tp_done_out <= tp_clr;
      if (tp_serve && tp_cmd_q == EFA_TP_ROM_RD) begin
        tp_sr <= rom[tp_addr_q[2:0]];  // [R13]
      end else if (tp_shift_in) begin
        tp_sr <= {tp_bit_in, tp_sr[BW-1:1]};
      end
      if (tp_go_in && (!tp_pend || tp_clr)) begin
        tp_pend <= 1'b1;
        tp_cmd_q <= tp_cmd_in;
        tp_addr_q <= tp_addr_in;
        tp_data_q <= tp_encrypted_in ? tp_sr ^ TP_KEY : tp_sr;  // [R10]
      end else if (tp_clr) begin
        tp_pend <= 1'b0;
      end
    end
  end

  assign tp_bit_out = tp_sr[0];

  // ****************************************************************
  // User ROM
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (tp_serve && tp_cmd_q == EFA_TP_ROM_WR) begin
      rom[tp_addr_q[2:0]] <= tp_data_q;  // [R11] [R12]
    end else if (tp_serve && tp_cmd_q == EFA_TP_ROM_ERASE) begin
      rom[tp_addr_q[2:0]] <= '1;  // [R12]
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rom_data_out <= '0;
    end else begin
      rom_data_out <= rom[rom_page_in];  // [R13]
    end
  end

endmodule : efa_ctrl

// >>> verif/efa_ctrl_assertions.sv
// Port checker of the flash array controller
`timescale 1ns/1ps
module efa_ctrl_chk #(
  parameter logic [1:0] ARRAY_ID = 2'h0
) (
  // Clock and reset
  input wire logic                 clk_sys_in,
  input wire logic                 arst_n_in,
  // Requests
  input wire logic                 req_in,
  input wire logic [1:0]           array_sel_in,
  input wire logic                 tp_go_in,
  input wire efa_pkg::efa_tp_cmd_t tp_cmd_in,
  // Answers
  input wire logic                 ack_out,
  input wire logic                 err_out,
  input wire logic                 busy_out,
  input wire logic [31:0]          rdata_out,
  input wire logic                 ecc_corr_out,
  input wire logic                 ecc_dbl_out,
  input wire logic                 tp_done_out
);
  import efa_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence take;
    req_in && !ack_out && !busy_out && array_sel_in == ARRAY_ID;
  endsequence
  sequence tp_take(logic arr);
    tp_go_in && !busy_out && ((tp_cmd_in == EFA_TP_ARRAY) == arr);
  endsequence
  chk_ack_pulse: assert property (ack_out |=> !ack_out)
    else $error("ack longer than one cycle");
  chk_take_busy: assert property (take |=> busy_out)
    else $error("busy low after take");
  chk_answer_bound: assert property (take |-> ##[1:18] ack_out)
    else $error("answer late");
  chk_ack_cause: assert property (ack_out |-> $past(req_in))
    else $error("ack without request");
  chk_err_ack: assert property (err_out |-> ack_out)
    else $error("refusal outside ack");
  chk_ecc_flags: assert property ((ecc_corr_out || ecc_dbl_out) |-> ack_out)
    else $error("ecc flag outside ack");
  chk_rdata_hold: assert property ($changed(rdata_out) |-> ack_out)
    else $error("read data moved without answer");
  chk_rom_done: assert property (tp_take(1'b0) |-> ##2 tp_done_out)
    else $error("rom command not done in two cycles");
  chk_tp_array: assert property (tp_take(1'b1) |-> ##3 tp_done_out)
    else $error("array command not done in three cycles");
  chk_done_pulse: assert property (tp_done_out |=> !tp_done_out)
    else $error("done longer than one cycle");
endmodule : efa_ctrl_chk

bind efa_ctrl efa_ctrl_chk #(.ARRAY_ID(ARRAY_ID)) u_chk (
  .clk_sys_in, .arst_n_in, .req_in, .array_sel_in, .tp_go_in, .tp_cmd_in,
  .ack_out, .err_out, .busy_out, .rdata_out, .ecc_corr_out, .ecc_dbl_out,
  .tp_done_out);

// >>> verif/efa_fabric_model.sv
// Fabric requester model driving the parallel handshake
`timescale 1ns/1ps
module efa_fabric_model (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  // Bench side
  input  wire logic go_in,
  output logic      done_out,
  output logic      err_seen_out,
  output logic      dbl_seen_out,
  // Controller side
  input  wire logic ack_in,
  input  wire logic err_in,
  input  wire logic dbl_in,
  output logic      req_out
);
  // Request held from launch up to the acknowledging edge
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_out <= 1'b0;
    end else if (ack_in) begin
      req_out <= 1'b0;
    end else if (go_in) begin
      req_out <= 1'b1;
    end
  end
  // Answer flags caught at the acknowledging edge
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_out <= 1'b0;
      err_seen_out <= 1'b0;
      dbl_seen_out <= 1'b0;
    end else begin
      done_out <= ack_in;
      if (ack_in) begin
        err_seen_out <= err_in;
        dbl_seen_out <= dbl_in;
      end
    end
  end
endmodule : efa_fabric_model

// >>> verif/efa_ctrl_tb.sv
// Self-checking bench of the flash array controller
`timescale 1ns/1ps
`include "efa_params.svh"
module efa_ctrl_tb;
  import efa_pkg::*;
  logic         clk = 0, rst_n = 0, req, go = 0, done, err_s, dbl_s;
  logic         ack, err, busy, ra = 0, pa = 0, tsh = 0, tbi = 0;
  logic         tgo = 0, tenc = 0, tbo, tdone, dbl_s_raw, corr, corr_s;
  efa_op_t      op = EFA_OP_READ;
  efa_width_t   wd = EFA_W32;
  efa_tp_cmd_t  tcmd = EFA_TP_ROM_WR;
  logic [5:0]   sec = 0, pg = 0, s, p;
  logic [6:0]   byt = 0, b;
  logic [2:0]   rpg = 0;
  logic [14:0]  taddr = 0;
  logic [31:0]  wdat = 0, rdat, v;
  logic [63:0]  psec = 0;
  logic [127:0] romd, rom, d;
  int           n_errors = 0, checks = 0, seed = 39, i, k;

  efa_ctrl #(.ARRAY_ID(2'h1)) dut (.clk_sys_in(clk), .arst_n_in(rst_n),
    .req_in(req), .op_in(op), .array_sel_in(2'h1), .sector_in(sec),
    .page_in(pg), .byte_in(byt), .width_in(wd), .wdata_in(wdat),
    .read_ahead_in(ra), .ack_out(ack), .err_out(err), .busy_out(busy),
    .rdata_out(rdat), .ecc_corr_out(corr), .ecc_dbl_out(dbl_s_raw),
    .prot_all_in(pa), .prot_sector_in(psec), .tp_shift_in(tsh),
    .tp_bit_in(tbi), .tp_go_in(tgo), .tp_cmd_in(tcmd),
    .tp_encrypted_in(tenc), .tp_addr_in(taddr), .tp_bit_out(tbo),
    .tp_done_out(tdone), .rom_page_in(rpg), .rom_data_out(romd));
  always @(posedge clk) begin
    if (ack) corr_s <= corr;
  end
  efa_fabric_model model (.clk_sys_in(clk), .arst_n_in(rst_n), .go_in(go),
    .done_out(done), .err_seen_out(err_s), .dbl_seen_out(dbl_s),
    .ack_in(ack), .err_in(err), .dbl_in(dbl_s_raw), .req_out(req));

  always #12.5 clk = ~clk;

  task tick;
    @(posedge clk);
    #2;
  endtask : tick

  task complete_run;
    $display("Comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [127:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task par(input efa_op_t o, input logic [6:0] c, input efa_width_t w);
    op = o;
    sec = s;
    pg = p;
    byt = c;
    wd = w;
    wdat = v;
    go = 1;
    tick;
    go = 0;
    for (i = 0; i < 40 && done !== 1'b1; i++) tick;
    chk("answer", 1, done);
    if (done !== 1'b1) complete_run;
  endtask : par

  task tport(input efa_tp_cmd_t c, input logic e, input logic [14:0] a);
    tsh = 1;
    for (i = 0; i < 128; i++) begin
      tbi = d[i];
      tick;
    end
    tsh = 0;
    tcmd = c;
    tenc = e;
    taddr = a;
    tgo = 1;
    tick;
    tgo = 0;
    for (i = 0; i < 10 && tdone !== 1'b1; i++) tick;
    chk("tp done", 1, tdone);
    if (tdone !== 1'b1) complete_run;
  endtask : tport

  function logic [127:0] tp_exp(input logic [127:0] x, input logic e);
    return e ? x ^ `EFA_TP_KEY : x;
  endfunction : tp_exp

  initial begin
    repeat (6) @(posedge clk);
    #2 rst_n = 1;
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    rom = d;
    tport(EFA_TP_ROM_WR, 0, 15'h2);
    d = ~rom;
    tport(EFA_TP_ROM_WR, 1, 15'h5);
    tport(EFA_TP_ROM_ERASE, 0, 15'h6);
    rpg = 3'h2;
    tick;
    tick;
    chk("rom page 2", rom, romd);
    rpg = 3'h5;
    tick;
    tick;
    chk("rom page 5", tp_exp(~rom, 1), romd);
    tport(EFA_TP_ROM_RD, 0, 15'h2);
    tsh = 1;
    for (k = 0; k < 8; k++) begin
      chk("rom serial", rom[k], tbo);
      tick;
    end
    tsh = 0;
    s = 6'h7;
    p = 6'h3;
    d = ~rom;
    tport(EFA_TP_ARRAY, 1, 15'(((7 * 33) + 3) * 8 + 2));
    par(EFA_OP_READ, 7'h20, EFA_W32);
    chk("tp array read", tp_exp(d, 1) & 128'hffffffff, rdat);
    for (k = 0; k < 4; k++) begin
      s = k == 0 ? 6'h3f : 6'($random(seed) & 32'h1f) + 6'h8;
      p = k == 0 ? 6'h20 : 6'($random(seed) & 32'h1f);
      b = 7'($random(seed)) & 7'h6c;
      v = 32'h0;
      par(EFA_OP_ERASE, 0, EFA_W32);
      v = $random(seed);
      par(EFA_OP_WRITE, b, EFA_W32);
      chk("write err", 0, err_s);
      par(EFA_OP_PROGRAM, b, EFA_W32);
      ra = 1;
      par(EFA_OP_READ, b, EFA_W32);
      ra = 0;
      chk("read word", v, rdat);
      chk("double flag", 0, dbl_s);
      chk("corrected", 0, corr_s);
      par(EFA_OP_READ, b + 7'h11, EFA_W8);
      chk("ahead byte", 8'hff, rdat[7:0]);
      par(EFA_OP_READ, b + 7'h1, EFA_W8);
      chk("read byte", v[15:8], rdat[7:0]);
      par(EFA_OP_READ, b + 7'h2, EFA_W16);
      chk("read half", v[31:16], rdat);
      psec[s] = 1'b1;
      par(EFA_OP_WRITE, b, EFA_W32);
      chk("protected", 1, err_s);
      psec = 64'h0;
    end
    pa = 1;
    par(EFA_OP_ERASE, 0, EFA_W32);
    chk("array protected", 1, err_s);
    complete_run;
  end
endmodule : efa_ctrl_tb
